//--- logic/sacr_consts.svh
// constants of the serial converter readout block
`ifndef SACR_CONSTS_SVH
`define SACR_CONSTS_SVH

// ************************************************
// word layout
// ************************************************
`define SACR_WORD_W 16
`define SACR_LEAD_W 4
`define SACR_CODE_W 12
`define SACR_CODE_MSB 11
`define SACR_CNT_W 4
// edge count value reached after the fifteenth falling edge
`define SACR_CNT_LAST 4'hF
// bit index shown by the first falling edge, before subtracting the count
`define SACR_IDX_FIRST 4'hE

// ************************************************
// timing
// ************************************************
`define SACR_CLK_PERIOD_NS 40
`define SACR_CONV_NS 3800
`define SACR_WAKE_CONV_NS 9800
`define SACR_QUIET_NS 300
`define SACR_SCLK_MAX_MHZ 15
// longest times round down to whole cycles
`define SACR_CONV_CYC ((`SACR_CONV_NS) / (`SACR_CLK_PERIOD_NS))
`define SACR_WAKE_CYC ((`SACR_WAKE_CONV_NS - `SACR_CONV_NS) / (`SACR_CLK_PERIOD_NS))
`define SACR_TIMER_W 8
`define SACR_TIMER_ZERO 8'h00

// ************************************************
// reset values
// ************************************************
`define SACR_SYNC_HIGH 3'h7
`define SACR_SYNC_LOW 3'h0
`define SACR_CODE_ZERO 12'h000
`define SACR_LEAD_ZERO 4'h0

`endif

//--- logic/sacr_pkg.sv
// types of the serial converter readout block
`include "sacr_consts.svh"

package sacr_pkg;

  // result word as it leaves the pin, leading zeros first
  typedef struct packed {
    logic [`SACR_LEAD_W-1:0] lead;
    logic [`SACR_CODE_W-1:0] code;
  } sacr_word_t;

  typedef enum logic [1:0] {
    SACR_IDLE,
    SACR_CONV,
    SACR_PWRDN,
    SACR_WAKE
  } sacr_state_t;

endpackage

//--- logic/sacr_link.sv
// serial clock side shifter of the result word
`timescale 1ns/100ps
`include "sacr_consts.svh"

module sacr_link (
  // link clock and clear from the core domain
  input wire logic sclk,
  input wire logic clr,
  // word, held stable by the core while clr is low
  input sacr_pkg::sacr_word_t word,
  // serial data and end of frame
  output logic sdo,
  output logic done
);

  logic [`SACR_CNT_W-1:0] cnt;
  wire logic [`SACR_WORD_W-1:0] bits = word;
  wire logic last_edge = (cnt == `SACR_CNT_LAST);
  wire logic [`SACR_CNT_W-1:0] next_cnt = cnt + 4'h1;
  wire logic [`SACR_CNT_W-1:0] next_idx = `SACR_IDX_FIRST - cnt;

  // the clock stands still between frames, so the core restarts the frame by
  // the async clear; cleared output is the first leading zero
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      cnt <= `SACR_LEAD_ZERO;
      sdo <= 1'b0;
      done <= 1'b0;
    end else if (!done) begin
      if (last_edge) begin
        done <= 1'b1;
      end else begin
        cnt <= next_cnt;
        sdo <= bits[next_idx];
      end
    end
  end

endmodule // sacr_link

//--- logic/sacr_top.sv
// conversion control and serial result readout of a 12-bit converter
// Operation
// - each falling serial clock edge puts the next result bit on the output
// - word is sixteen bits: four zeros then twelve result bits
// - after the sixteenth falling edge last bit holds, then output floats
// - two's complement for bipolar variants, straight binary for unipolar
// - busy rises on the falling edge of convert start
// - busy falls when the conversion completes
// - convert start falling edge holds the sample and starts conversion
// - convert start still low at conversion end puts the part to sleep
// - asleep, the rising edge of convert start wakes the part
// - conversion takes 3.8 us; wake plus conversion takes 9.8 us
`timescale 1ns/100ps
`include "sacr_consts.svh"

module sacr_top #(
  parameter bit BIPOLAR = 1'b1,
  parameter int unsigned CONV_CYCLES = `SACR_CONV_CYC,
  parameter int unsigned WAKE_CYCLES = `SACR_WAKE_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion control pins
  input wire logic convert_start_n,
  output logic conversion_busy,
  output logic power_down,
  // successive approximation decisions, offset binary, msb first
  input wire logic [`SACR_CODE_W-1:0] sar_code,
  // serial readout pins
  input wire logic sclk,
  output logic serial_result_out,
  output logic serial_result_oe
);

  // ************************************************
  // convert start input conditioning
  // ************************************************
  logic [2:0] start_sync;
  logic start_lvl;
  logic start_lvl_q;

  // a change counts only when the second and third stage agree
  wire logic start_agree = (start_sync[1] == start_sync[2]);
  wire logic next_start_lvl = start_agree ? start_sync[2] : start_lvl;
  wire logic start_fall = start_lvl_q & ~start_lvl;
  wire logic start_rise = ~start_lvl_q & start_lvl;

  always_ff @(posedge clk) begin
    if (rst) begin
      start_sync <= `SACR_SYNC_HIGH;
      start_lvl <= 1'b1;
      start_lvl_q <= 1'b1;
    end else begin
      start_sync <= {start_sync[1:0], convert_start_n};
      start_lvl <= next_start_lvl;
      start_lvl_q <= start_lvl;
    end
  end

  // ************************************************
  // end of frame from the serial clock side
  // ************************************************
  logic link_done;
  logic [2:0] done_sync;
  logic done_lvl;

  wire logic done_agree = (done_sync[1] == done_sync[2]);
  wire logic next_done_lvl = done_agree ? done_sync[2] : done_lvl;

  always_ff @(posedge clk) begin
    if (rst) begin
      done_sync <= `SACR_SYNC_LOW;
      done_lvl <= 1'b0;
    end else begin
      done_sync <= {done_sync[1:0], link_done};
      done_lvl <= next_done_lvl;
    end
  end

  // ************************************************
  // sequencing
  // ************************************************
  sacr_pkg::sacr_state_t state;
  sacr_pkg::sacr_state_t next_state;
  logic [`SACR_TIMER_W-1:0] timer;
  logic pend;

  wire logic st_idle = (state == sacr_pkg::SACR_IDLE);
  wire logic st_conv = (state == sacr_pkg::SACR_CONV);
  wire logic st_pwrdn = (state == sacr_pkg::SACR_PWRDN);
  wire logic st_wake = (state == sacr_pkg::SACR_WAKE);
  wire logic timer_zero = (timer == `SACR_TIMER_ZERO);

  // the sample is frozen on the falling edge even while still waking, so the
  // held value is the one at the edge, not at the end of wake-up
  wire logic capture = start_fall & (st_idle | st_wake);
  // a falling edge during conversion is ignored: no retrigger
  wire logic go_conv = (st_idle & start_fall) | (st_wake & timer_zero & (pend | start_fall));
  wire logic conv_done = st_conv & timer_zero;
  wire logic wake_go = st_pwrdn & start_rise;
  wire logic next_pend = st_wake & ~timer_zero & (pend | start_fall);

  wire logic [`SACR_TIMER_W-1:0] conv_load = `SACR_TIMER_W'(CONV_CYCLES - 1);
  wire logic [`SACR_TIMER_W-1:0] wake_load = `SACR_TIMER_W'(WAKE_CYCLES - 1);
  wire logic [`SACR_TIMER_W-1:0] timer_dec = timer - 8'h01;
  wire logic [`SACR_TIMER_W-1:0] next_timer =
    go_conv ? conv_load :
    wake_go ? wake_load :
    timer_zero ? timer : timer_dec;

  always_comb begin
    next_state = state;
    unique case (state)
      sacr_pkg::SACR_IDLE: begin
        if (capture) begin
          next_state = sacr_pkg::SACR_CONV;
        end
      end
      sacr_pkg::SACR_CONV: begin
        if (timer_zero) begin
          // still low at the end of conversion means auto sleep
          next_state = start_lvl ? sacr_pkg::SACR_IDLE : sacr_pkg::SACR_PWRDN;
        end
      end
      sacr_pkg::SACR_PWRDN: begin
        if (start_rise) begin
          next_state = sacr_pkg::SACR_WAKE;
        end
      end
      sacr_pkg::SACR_WAKE: begin
        if (timer_zero) begin
          next_state = go_conv ? sacr_pkg::SACR_CONV : sacr_pkg::SACR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sacr_pkg::SACR_IDLE;
      timer <= `SACR_TIMER_ZERO;
      pend <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pend <= next_pend;
    end
  end

  // ************************************************
  // busy and power-down status pins
  // ************************************************
  wire logic next_busy = capture | (conversion_busy & ~conv_done);
  wire logic next_pd = (next_state == sacr_pkg::SACR_PWRDN);

  always_ff @(posedge clk) begin
    if (rst) begin
      conversion_busy <= 1'b0;
      power_down <= 1'b0;
    end else begin
      conversion_busy <= next_busy;
      power_down <= next_pd;
    end
  end

  // ************************************************
  // held sample and result word
  // ************************************************
  logic [`SACR_CODE_W-1:0] sample;
  sacr_pkg::sacr_word_t xfer_word;

  // bipolar coding flips the msb of the offset binary decisions
  wire logic [`SACR_CODE_W-1:0] coded = BIPOLAR ?
    {~sample[`SACR_CODE_MSB], sample[`SACR_CODE_MSB-1:0]} : sample;
  sacr_pkg::sacr_word_t next_word;
  assign next_word.lead = `SACR_LEAD_ZERO;
  assign next_word.code = coded;

  always_ff @(posedge clk) begin
    if (rst) begin
      sample <= `SACR_CODE_ZERO;
      xfer_word <= '0;
    end else begin
      if (capture) begin
        sample <= sar_code;
      end
      if (conv_done) begin
        xfer_word <= next_word;
      end
    end
  end

  // ************************************************
  // readout window
  // ************************************************
  // the word only changes while the link is held clear, so the serial side
  // reads a quiet word; a new conversion aborts a readout still under way
  logic link_clr;
  wire logic next_oe = conv_done | (serial_result_oe & ~done_lvl & ~capture);

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_result_oe <= 1'b0;
      link_clr <= 1'b1;
    end else begin
      serial_result_oe <= next_oe;
      link_clr <= ~next_oe;
    end
  end

  // ************************************************
  // serial clock side
  // ************************************************
  sacr_link u_link (
    .sclk(sclk),
    .clr(link_clr),
    .word(xfer_word),
    .sdo(serial_result_out),
    .done(link_done)
  );

endmodule // sacr_top

//--- testbench/sacr_top_props.sv
// assertions on the ports of the converter readout block
`timescale 1ns/100ps

module sacr_top_props #(
  parameter int unsigned CONV_CYCLES = 20,
  parameter int unsigned WAKE_CYCLES = 30
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion and readout status
  input wire logic convert_start_n,
  input wire logic conversion_busy,
  input wire logic power_down,
  input wire logic serial_result_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  localparam int unsigned WC = WAKE_CYCLES + CONV_CYCLES;
  logic pd_q;
  logic busy_q;
  logic waking;
  logic [9:0] busy_cnt;
  logic [9:0] wake_cnt;
  wire pd_fell = pd_q && !power_down;
  // slack of a few cycles covers the pin synchroniser
  wire wake_ok = wake_cnt + 3 >= WC && wake_cnt <= WC + 2;
  always_ff @(posedge clk) begin
    pd_q <= power_down;
    busy_q <= conversion_busy;
    busy_cnt <= conversion_busy ? busy_cnt + 10'h001 : 10'h000;
    wake_cnt <= pd_fell ? 10'h001 : wake_cnt + 10'h001;
    waking <= !rst && (pd_fell || (waking && !(busy_q && !conversion_busy)));
  end
  sequence s_idle_fall; $fell(convert_start_n) && !conversion_busy && !power_down; endsequence
  sequence s_conv_end; $fell(conversion_busy); endsequence
  property p_busy_rise; s_idle_fall |-> ##[3:6] conversion_busy; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");
  property p_conv_len; s_conv_end ##0 !waking |-> busy_cnt == CONV_CYCLES; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_wake_len; s_conv_end ##0 waking |-> wake_ok; endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake length");
  property p_sleep; s_conv_end ##0 !convert_start_n |-> power_down; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_excl; power_down |-> !conversion_busy; endproperty
  a_excl: assert property (p_excl) else $error("busy while asleep");
  property p_wake; power_down && $rose(convert_start_n) |-> ##[3:6] !power_down; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_oe_on; s_conv_end |-> serial_result_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("result not offered");
  property p_abort; $rose(conversion_busy) |-> !serial_result_oe; endproperty
  a_abort: assert property (p_abort) else $error("drive during conversion");
endmodule // sacr_top_props

bind sacr_top sacr_top_props #(.CONV_CYCLES(CONV_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_props (
  .clk(clk), .rst(rst), .convert_start_n(convert_start_n), .conversion_busy(conversion_busy),
  .power_down(power_down), .serial_result_oe(serial_result_oe));

//--- testbench/sacr_host.sv
// host model that clocks the result word out of the converter
`timescale 1ns/100ps

module sacr_host (
  // serial clock towards the converter
  output logic sclk,
  // data pin and its enable
  input wire logic sdo,
  input wire logic oe
);
  // a released pin reads as the inverse of its last value
  wire line = oe ? sdo : ~sdo;
  initial sclk = 1'b0;
  task automatic read(output logic [15:0] w, output logic held);
    w = 16'h0000;
    #13;
    repeat (16) begin
      sclk = 1'b1;
      #40;
      // take the bit standing at the falling edge before the edge can move it
      w = {w[14:0], line};
      sclk = 1'b0;
      #10;
      held = line;
      #30;
    end
  endtask
endmodule // sacr_host

//--- testbench/testbench.sv
// self-checking bench of the converter readout block
`timescale 1ns/100ps
`include "sacr_consts.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  localparam int unsigned CONV = 20;
  localparam int unsigned WAKE = 30;
  localparam int unsigned WC = WAKE + CONV;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic convert_start_n = 1'b1;
  logic [`SACR_CODE_W-1:0] sar_code = 12'h000;
  logic sclk;
  logic busy;
  logic pd;
  logic sdo;
  logic oe;
  logic busy_uni;
  logic pd_uni;
  logic sdo_uni;
  logic oe_uni;
  logic [15:0] w_uni = 16'h0000;
  int error_cnt = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h00013D8B;
  logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};

  always #20 clk = ~clk;

  sacr_top #(.BIPOLAR(1'b1), .CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) dut (
    .clk(clk), .rst(rst), .convert_start_n(convert_start_n), .conversion_busy(busy),
    .power_down(pd), .sar_code(sar_code), .sclk(sclk), .serial_result_out(sdo),
    .serial_result_oe(oe));
  sacr_host host (.sclk(sclk), .sdo(sdo), .oe(oe));
  // the straight binary part shares every input with the bipolar one
  sacr_top #(.BIPOLAR(1'b0), .CONV_CYCLES(CONV), .WAKE_CYCLES(WAKE)) dut_uni (
    .clk(clk), .rst(rst), .convert_start_n(convert_start_n), .conversion_busy(busy_uni),
    .power_down(pd_uni), .sar_code(sar_code), .sclk(sclk), .serial_result_out(sdo_uni),
    .serial_result_oe(oe_uni));
  // bits stand settled at the rising serial edge, so the sixteen rising edges
  // of one readout leave the whole word here
  always @(posedge sclk) w_uni <= {w_uni[14:0], oe_uni ? sdo_uni : ~sdo_uni};

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bipolar parts flip the msb of the offset binary decisions
  function automatic logic [15:0] expect_word(input logic [11:0] c, input bit bip);
    return {4'h0, bip ? c ^ 12'h800 : c};
  endfunction

  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // sl leaves the pin low to sleep, g adds an ignored start, wk wakes first,
  // and without rd the word stays offered for the next start to withdraw
  task automatic run(input logic [11:0] c, input bit sl, input bit g, input bit wk,
    input bit rd);
    int n;
    int len;
    int t;
    logic [15:0] w;
    logic held;
    n = 0;
    len = 0;
    t = 0;
    sar_code = c;
    // keep the last readout well clear of the next sampling edge
    repeat (8) @(negedge clk);
    if (wk) begin
      convert_start_n = 1'b1;
      repeat (8) @(negedge clk);
      n = 8;
    end
    convert_start_n = 1'b0;
    while (!busy && n < 60) begin
      @(negedge clk);
      n++;
    end
    `CHK("withdrawn", 1'b0, oe)
    // the held sample must not follow the decisions after the falling edge
    sar_code = ~c;
    while (busy && len < 400) begin
      @(negedge clk);
      len++;
      if (len == 2 && !sl) convert_start_n = 1'b1;
      if (g && len == 6) convert_start_n = 1'b0;
      if (g && len == 10) convert_start_n = 1'b1;
    end
    t = n + len;
    if (wk) `CHK("wake_time", 1'b1, (t >= WC + 2) && (t <= WC + 7))
    else `CHK("busy_cycles", CONV, len)
    `CHK("power_down", sl, pd)
    if (rd) begin
      host.read(w, held);
      @(negedge clk);
      `CHK("word", expect_word(c, 1'b1), w)
      `CHK("word_uni", expect_word(c, 1'b0), w_uni)
      `CHK("hold_bit", c[0], held)
      n = 0;
      while (oe && n < 20) begin
        @(negedge clk);
        n++;
      end
      `CHK("released", 1'b0, oe)
    end else begin
      repeat (20) @(negedge clk);
      `CHK("offered", 1'b1, oe)
    end
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    foreach (corner[i]) run(corner[i], 1'b0, i[0], 1'b0, 1'b1);
    // a word left unread must be withdrawn by the next start
    run(12'h5A5, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (6) begin
      seed = lfsr(seed);
      run(seed[11:0], 1'b0, seed[12], 1'b0, 1'b1);
    end
    repeat (2) begin
      seed = lfsr(seed);
      run(seed[11:0], 1'b1, 1'b0, 1'b0, 1'b1);
      run(~seed[11:0], 1'b0, 1'b0, 1'b1, 1'b1);
    end
    summarize();
  end

  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
endmodule // testbench
